// ---- hdl/charger_regs_map.svh ----
// offsets, field positions, reset values and timing figures of the charger register bank
`ifndef CHARGER_REGS_MAP_SVH
`define CHARGER_REGS_MAP_SVH

`define CLK_FREQ_HZ           100000000
`define OFS_INPUT_LIMIT_CTRL  8'h00
`define OFS_BOOST_TEMP_VFLOOR 8'h01
`define OFS_LAST              8'h01
`define RST_INPUT_LIMIT_CTRL  8'h08
`define RST_BOOST_TEMP_VFLOOR 8'h06
`define READ_UNMAPPED         8'hFF
`define I2C_ADDR_SWITCHED     7'h6A
`define I2C_ADDR_PIN_SELECT   7'h6B

`define BIT_HIGH_IMPEDANCE    7
`define BIT_EXT_LIMIT_ENABLE  6
`define BIT_BOOST_COLD        5
// fields kept across a watchdog expiry
`define KEEP_MASK_REG0        8'h3F
`define KEEP_MASK_REG1        8'h1F

`define LIMIT_CODE_500MA      6'h08
`define LIMIT_CODE_1500MA     6'h1C
`define LIMIT_CODE_3250MA     6'h3F

`define HOT_PCT_X100_CODE0    16'h0D93
`define HOT_PCT_X100_CODE1    16'h0EBF
`define HOT_PCT_X100_CODE2    16'h0C35
`define COLD_PCT_X100_CODE0   16'h1E14
`define COLD_PCT_X100_CODE1   16'h1F40

`define FLOOR_OFS_STEP_MV     17'h0_0064
`define FLOOR_MIN_MV          17'h0_0F3C
`define FLOOR_MAX_MV          17'h0_3BC4
`define VBUS_DOUBLE_ABOVE_MV  16'h1770

`define SAFETY_TIME_HOURS     12
`define WD_PERIOD_OFF         2'b00

`endif

// ---- hdl/charger_regs_pkg.sv ----
// types shared by the charger register bank
package charger_regs_pkg;
  typedef enum logic [1:0] {
    SRC_SDP_OR_UNKNOWN = 2'b00,
    SRC_CDP            = 2'b01,
    SRC_DCP            = 2'b10
  } source_t;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'b0_0000_0001,
    ST_ADDR      = 9'b0_0000_0010,
    ST_ADDR_ACK  = 9'b0_0000_0100,
    ST_REG       = 9'b0_0000_1000,
    ST_REG_ACK   = 9'b0_0001_0000,
    ST_WDATA     = 9'b0_0010_0000,
    ST_WDATA_ACK = 9'b0_0100_0000,
    ST_RDATA     = 9'b0_1000_0000,
    ST_RDATA_ACK = 9'b1_0000_0000
  } link_state_t;
endpackage

// ---- hdl/charger_host_mode_register_bank.sv ----
// two-register mode-control bank of a serially managed charger, with watchdog and safety timer
`timescale 1ns/1ns
`include "charger_regs_map.svh"

module charger_host_mode_register_bank #(
  parameter bit          PIN_SELECT_VARIANT = 1'b0,
  parameter logic [47:0] WD_CYCLES_SEL1     = 48'h0000_0000_1000,
  parameter logic [47:0] WD_CYCLES_SEL2     = 48'h0000_0000_2000,
  parameter logic [47:0] WD_CYCLES_SEL3     = 48'h0000_0000_4000,
  parameter logic [47:0] SAFETY_CYCLES      =
    48'(64'(`SAFETY_TIME_HOURS) * 64'd3600 * 64'(`CLK_FREQ_HZ))
) (
  // clock and reset
  input  wire logic                             I_SYS_CLK,
  input  wire logic                             I_RESET,
  // serial link, open drain data
  input  wire logic                             I_SCL,
  input  wire logic                             I_SDA,
  output logic                                  O_SDA_OUT,
  output logic                                  O_SDA_OE,
  // watchdog control and register reset
  input  wire logic                             I_TIMER_KICK,
  input  wire logic [1:0]                       I_WD_PERIOD,
  input  wire logic                             I_REG_RESET,
  // source detection
  input  wire logic                             I_DETECT_DONE,
  input  wire charger_regs_pkg::source_t        I_SOURCE_TYPE,
  input  wire logic                             I_PIN_SELECT,
  // analog side measurements
  input  wire logic [5:0]                       I_EXT_LIMIT_CODE,
  input  wire logic [15:0]                      I_FLOOR_BASE_MV,
  input  wire logic [15:0]                      I_VBUS_NOLOAD_MV,
  // mode and control outputs
  output logic                                  O_TIMER_EXPIRED,
  output logic                                  O_TIMER_KICK,
  output logic                                  O_CHARGE_ENABLE,
  output logic                                  O_HIGH_IMPEDANCE_STATE,
  output logic                                  O_EXT_LIMIT_PIN_ENABLE,
  output logic [5:0]                            O_INPUT_CURRENT_LIMIT,
  output logic [5:0]                            O_EFFECTIVE_LIMIT,
  output logic [15:0]                           O_BOOST_HOT_PCT_X100,
  output logic                                  O_BOOST_THERMAL_DISABLE,
  output logic [15:0]                           O_BOOST_COLD_PCT_X100,
  output logic [15:0]                           O_INPUT_VOLTAGE_FLOOR_MV
);
  import charger_regs_pkg::*;

  localparam logic [6:0] DEV_ADDR =
    PIN_SELECT_VARIANT ? `I2C_ADDR_PIN_SELECT : `I2C_ADDR_SWITCHED;

  // ---------------- serial slave ----------------
  logic        scl_q, sda_q;
  logic        scl_rise, scl_fall, start_seen, stop_seen;
  link_state_t st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  shift_q, shift_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        oe_q, oe_d;
  logic        wr_q, wr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [7:0]  rd_byte;
  logic [7:0]  reg0_q, reg0_d, reg1_q, reg1_d;
  logic [7:0]  shift_in;

  assign scl_rise   = I_SCL & ~scl_q;
  assign scl_fall   = ~I_SCL & scl_q;
  assign start_seen = scl_q & I_SCL & sda_q & ~I_SDA;
  assign stop_seen  = scl_q & I_SCL & ~sda_q & I_SDA;
  assign shift_in   = {shift_q[6:0], I_SDA};

  always_comb begin
    case (ptr_q)
      `OFS_INPUT_LIMIT_CTRL:  rd_byte = reg0_q;
      `OFS_BOOST_TEMP_VFLOOR: rd_byte = reg1_q;
      default:                rd_byte = `READ_UNMAPPED;
    endcase
  end

  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    oe_d    = oe_q;
    wr_d    = 1'b0;
    wdata_d = wdata_q;
    if (start_seen) begin
      st_d  = ST_ADDR;
      bit_d = 3'h0;
      oe_d  = 1'b0;
    end else if (stop_seen) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise) begin
            shift_d = shift_in;
            bit_d   = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d = ST_IDLE;
              if (st_q == ST_ADDR && shift_in[7:1] == DEV_ADDR) begin
                st_d = ST_ADDR_ACK;
              end else if (st_q == ST_REG && shift_in <= `OFS_LAST) begin
                ptr_d = shift_in;
                st_d  = ST_REG_ACK;
              end else if (st_q == ST_WDATA && ptr_q <= `OFS_LAST) begin
                wr_d    = 1'b1;
                wdata_d = shift_in;
                st_d    = ST_WDATA_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (!oe_q) begin
              oe_d = 1'b1;
            end else begin
              oe_d  = 1'b0;
              bit_d = 3'h0;
              st_d  = ST_WDATA;
              if (st_q == ST_WDATA_ACK) begin
                ptr_d = ptr_q + 8'h01;
              end else if (st_q == ST_ADDR_ACK && shift_q[0]) begin
                st_d    = ST_RDATA;
                oe_d    = ~rd_byte[7];
                shift_d = {rd_byte[6:0], 1'b0};
              end else if (st_q == ST_ADDR_ACK) begin
                st_d = ST_REG;
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            oe_d    = ~shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
          end else if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              st_d  = ST_RDATA_ACK;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
          end else if (scl_rise) begin
            st_d    = I_SDA ? ST_IDLE : ST_RDATA;
            shift_d = rd_byte;
            bit_d   = 3'h0;
          end
        end
        default: begin
          st_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      st_q    <= ST_IDLE;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      oe_q    <= 1'b0;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      scl_q   <= I_SCL;
      sda_q   <= I_SDA;
      st_q    <= st_d;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      oe_q    <= oe_d;
      wr_q    <= wr_d;
      wdata_q <= wdata_d;
    end
  end

  // ---------------- mode, watchdog, safety timer ----------------
  logic        default_mode_q, default_mode_d;
  logic [47:0] wd_cnt_q, wd_cnt_d, wd_limit;
  logic [47:0] safety_cnt_q, safety_cnt_d;
  logic        charge_en_q, charge_en_d;
  logic        kick_q, kick_d;
  logic        wd_expire;
  logic        wd_restart;

  always_comb begin
    case (I_WD_PERIOD)
      2'b01:   wd_limit = WD_CYCLES_SEL1;
      2'b10:   wd_limit = WD_CYCLES_SEL2;
      default: wd_limit = WD_CYCLES_SEL3;
    endcase
  end

  // period 00 clears the counter so host mode never times out
  assign wd_expire  = !default_mode_q && I_WD_PERIOD != `WD_PERIOD_OFF &&
                      wd_cnt_q >= wd_limit - 48'h1;
  assign wd_restart = kick_q | wr_q;

  always_comb begin
    default_mode_d = default_mode_q;
    wd_cnt_d       = wd_cnt_q;
    safety_cnt_d   = safety_cnt_q;
    charge_en_d    = charge_en_q;
    kick_d         = kick_q;
    if (wr_q) begin
      default_mode_d = 1'b0;
    end else if (wd_expire) begin
      default_mode_d = 1'b1;
    end
    if (default_mode_q || wd_restart || I_WD_PERIOD == `WD_PERIOD_OFF) begin
      wd_cnt_d = 48'h0;
    end else begin
      wd_cnt_d = wd_cnt_q + 48'h1;
    end
    // restart is taken the cycle after the kick, then the bit drops
    if (I_TIMER_KICK) begin
      kick_d = 1'b1;
    end else if (kick_q) begin
      kick_d = 1'b0;
    end
    if (!default_mode_q) begin
      safety_cnt_d = 48'h0;
      charge_en_d  = 1'b1;
    end else if (safety_cnt_q >= SAFETY_CYCLES - 48'h1) begin
      charge_en_d = 1'b0;
    end else begin
      safety_cnt_d = safety_cnt_q + 48'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      default_mode_q <= 1'b1;
      wd_cnt_q       <= 48'h0;
      safety_cnt_q   <= 48'h0;
      charge_en_q    <= 1'b1;
      kick_q         <= 1'b0;
    end else begin
      default_mode_q <= default_mode_d;
      wd_cnt_q       <= wd_cnt_d;
      safety_cnt_q   <= safety_cnt_d;
      charge_en_q    <= charge_en_d;
      kick_q         <= kick_d;
    end
  end

  // ---------------- register storage ----------------
  logic [5:0] detect_code;

  always_comb begin
    case (I_SOURCE_TYPE)
      SRC_CDP: detect_code = `LIMIT_CODE_1500MA;
      SRC_DCP: detect_code = `LIMIT_CODE_3250MA;
      default: detect_code = `LIMIT_CODE_500MA;
    endcase
    if (PIN_SELECT_VARIANT) begin
      detect_code = I_PIN_SELECT ? `LIMIT_CODE_500MA : `LIMIT_CODE_3250MA;
    end
  end

  always_comb begin
    reg0_d = reg0_q;
    reg1_d = reg1_q;
    if (I_REG_RESET) begin
      reg0_d = `RST_INPUT_LIMIT_CTRL;
      reg1_d = `RST_BOOST_TEMP_VFLOOR;
    end else if (wd_expire) begin
      reg0_d = (reg0_q & `KEEP_MASK_REG0) | (`RST_INPUT_LIMIT_CTRL & ~`KEEP_MASK_REG0);
      reg1_d = (reg1_q & `KEEP_MASK_REG1) | (`RST_BOOST_TEMP_VFLOOR & ~`KEEP_MASK_REG1);
    end else if (wr_q && ptr_q == `OFS_INPUT_LIMIT_CTRL) begin
      reg0_d = wdata_q;
    end else if (wr_q) begin
      reg1_d = wdata_q;
    end
    if (I_DETECT_DONE && !I_REG_RESET) begin
      reg0_d[5:0] = detect_code;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      reg0_q <= `RST_INPUT_LIMIT_CTRL;
      reg1_q <= `RST_BOOST_TEMP_VFLOOR;
    end else begin
      reg0_q <= reg0_d;
      reg1_q <= reg1_d;
    end
  end

  // ---------------- derived outputs ----------------
  logic [5:0]  eff_q, eff_d;
  logic [15:0] hot_q, hot_d, cold_q, cold_d, floor_q, floor_d;
  logic        hot_off_q, hot_off_d;
  logic [16:0] ofs_mv, floor_sum;

  always_comb begin
    eff_d = reg0_q[5:0];
    if (reg0_q[`BIT_EXT_LIMIT_ENABLE] && I_EXT_LIMIT_CODE < reg0_q[5:0]) begin
      eff_d = I_EXT_LIMIT_CODE;
    end
    hot_off_d = 1'b0;
    case (reg1_q[7:6])
      2'b00:   hot_d = `HOT_PCT_X100_CODE0;
      2'b01:   hot_d = `HOT_PCT_X100_CODE1;
      2'b10:   hot_d = `HOT_PCT_X100_CODE2;
      default: begin
        hot_d     = `HOT_PCT_X100_CODE0;
        hot_off_d = 1'b1;
      end
    endcase
    cold_d = reg1_q[`BIT_BOOST_COLD] ? `COLD_PCT_X100_CODE1 : `COLD_PCT_X100_CODE0;
    ofs_mv = 17'(reg1_q[4:0]) * `FLOOR_OFS_STEP_MV;
    if (I_VBUS_NOLOAD_MV > `VBUS_DOUBLE_ABOVE_MV) begin
      ofs_mv = {ofs_mv[15:0], 1'b0};
    end
    floor_sum = 17'(I_FLOOR_BASE_MV) + ofs_mv;
    if (floor_sum < `FLOOR_MIN_MV) begin
      floor_sum = `FLOOR_MIN_MV;
    end else if (floor_sum > `FLOOR_MAX_MV) begin
      floor_sum = `FLOOR_MAX_MV;
    end
    floor_d = floor_sum[15:0];
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      eff_q     <= 6'h00;
      hot_q     <= `HOT_PCT_X100_CODE0;
      hot_off_q <= 1'b0;
      cold_q    <= `COLD_PCT_X100_CODE0;
      floor_q   <= 16'(`FLOOR_MIN_MV);
    end else begin
      eff_q     <= eff_d;
      hot_q     <= hot_d;
      hot_off_q <= hot_off_d;
      cold_q    <= cold_d;
      floor_q   <= floor_d;
    end
  end

  assign O_SDA_OUT                = 1'b0;
  assign O_SDA_OE                 = oe_q;
  assign O_TIMER_EXPIRED          = default_mode_q;
  assign O_TIMER_KICK             = kick_q;
  assign O_CHARGE_ENABLE          = charge_en_q;
  assign O_HIGH_IMPEDANCE_STATE   = reg0_q[`BIT_HIGH_IMPEDANCE];
  assign O_EXT_LIMIT_PIN_ENABLE   = reg0_q[`BIT_EXT_LIMIT_ENABLE];
  assign O_INPUT_CURRENT_LIMIT    = reg0_q[5:0];
  assign O_EFFECTIVE_LIMIT        = eff_q;
  assign O_BOOST_HOT_PCT_X100     = hot_q;
  assign O_BOOST_THERMAL_DISABLE  = hot_off_q;
  assign O_BOOST_COLD_PCT_X100    = cold_q;
  assign O_INPUT_VOLTAGE_FLOOR_MV = floor_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);

  property p_write_enters_host;
    wr_q |=> !default_mode_q;
  endproperty
  a_write_enters_host: assert property (p_write_enters_host)
    else $error("write did not enter host mode");

  // a write in the expiry cycle keeps host mode, so it is left out here
  property p_expired_flag;
    wd_expire && !wr_q |=> O_TIMER_EXPIRED && !$past(O_TIMER_EXPIRED);
  endproperty
  a_expired_flag: assert property (p_expired_flag)
    else $error("timer expired flag wrong");

  property p_wd_off;
    I_WD_PERIOD == `WD_PERIOD_OFF && !default_mode_q |=> !O_TIMER_EXPIRED;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog expired while disabled");

  property p_expiry_keeps_limit;
    wd_expire && !I_REG_RESET && !I_DETECT_DONE |=>
      reg0_q[5:0] == $past(reg0_q[5:0]) && reg1_q[4:0] == $past(reg1_q[4:0]) &&
      reg0_q[7:6] == 2'b00 && reg1_q[7:5] == 3'b000;
  endproperty
  a_expiry_keeps_limit: assert property (p_expiry_keeps_limit)
    else $error("expiry reload wrong");

  property p_reg_reset;
    I_REG_RESET |=> reg0_q == `RST_INPUT_LIMIT_CTRL && reg1_q == `RST_BOOST_TEMP_VFLOOR;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset incomplete");

  property p_kick_clears;
    kick_q && !I_TIMER_KICK |=> !kick_q ##0 wd_cnt_q == 48'h0;
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick did not clear after restart");

  property p_detect_load;
    I_DETECT_DONE && !I_REG_RESET |=> reg0_q[5:0] == $past(detect_code);
  endproperty
  a_detect_load: assert property (p_detect_load)
    else $error("detection did not load limit");

  property p_effective_min;
    ##1 (O_EFFECTIVE_LIMIT <= $past(reg0_q[5:0]));
  endproperty
  a_effective_min: assert property (p_effective_min)
    else $error("effective limit above register");

  property p_floor_clamp;
    O_INPUT_VOLTAGE_FLOOR_MV >= 16'(`FLOOR_MIN_MV) &&
    O_INPUT_VOLTAGE_FLOOR_MV <= 16'(`FLOOR_MAX_MV);
  endproperty
  a_floor_clamp: assert property (p_floor_clamp)
    else $error("floor threshold out of clamp");

  property p_host_charges;
    !default_mode_q |=> O_CHARGE_ENABLE;
  endproperty
  a_host_charges: assert property (p_host_charges)
    else $error("charging stopped in host mode");

endmodule // charger_host_mode_register_bank

// ---- tb/host_i2c_model.sv ----
// host-side two-wire master model for the charger register bank
`timescale 1ns/1ns
module host_i2c_model (
  // bit timebase
  input  wire logic i_clk,
  // resolved data line
  input  wire logic i_sda,
  // master drives, open drain data
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // four clocks a phase, twice what the slave needs
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic put_bit(input logic b);
    o_sda_low = ~b;
    half();
    o_scl = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask
  task automatic get_bit(output logic b);
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    b     = i_sda;
    o_scl = 1'b0;
    half();
  endtask
  // also serves as repeated start
  task automatic start();
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b0;
    half();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] d, output logic [2:0] acks);
    start();
    send({dev, 1'b0}, acks[2]);
    send(ofs, acks[1]);
    send(d, acks[0]);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] d, output logic [2:0] acks);
    start();
    send({dev, 1'b0}, acks[2]);
    send(ofs, acks[1]);
    start();
    send({dev, 1'b1}, acks[0]);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);  // nack ends the read
    stop();
  endtask
endmodule // host_i2c_model

// ---- tb/charger_host_mode_register_bank_bench.sv ----
// self-checking bench for the charger register bank
`timescale 1ns/1ns
`include "charger_regs_map.svh"
module charger_host_mode_register_bank_bench;
  import charger_regs_pkg::*;
  localparam logic [6:0] DEV = `I2C_ADDR_SWITCHED;
  logic        clk = 1'b0, rst = 1'b1, kick = 1'b0, reg_rst = 1'b0, det = 1'b0;
  logic [1:0]  period = 2'b00;
  source_t     src = SRC_SDP_OR_UNKNOWN;
  logic [5:0]  ext = 6'h3F;
  logic [15:0] base = 16'h0FA0;
  logic [15:0] vbus = 16'h1388;
  logic        scl, sda_low, sda_out, sda_oe, sda;
  logic        expired, kick_out, chg, high_impedance_state, pin_en, tdis;
  logic [5:0]  lim, eff;
  logic [15:0] hot, cold, floor_mv;
  logic [7:0]  rdata;
  logic [2:0]  acks;
  int          err_total = 0;
  int          total_checks = 0;
  int          wd_len [3] = '{50, 100, 150};
  logic [15:0] hot_tab [3] = '{`HOT_PCT_X100_CODE0, `HOT_PCT_X100_CODE1, `HOT_PCT_X100_CODE2};
  logic [5:0]  det_tab [4] = '{`LIMIT_CODE_500MA, `LIMIT_CODE_1500MA, `LIMIT_CODE_3250MA,
                               `LIMIT_CODE_500MA};
  logic [15:0] fb [4] = '{16'h0FA0, 16'h0FA0, 16'h0BB8, 16'h3A98};
  logic [15:0] fv [4] = '{16'h1770, 16'h1771, 16'h1388, 16'h1B58};
  logic [4:0]  fo [4] = '{5'h06, 5'h06, 5'h00, 5'h1F};
  logic [15:0] fe [4] = '{16'h11F8, 16'h1450, 16'h0F3C, 16'h3BC4};
  always #5 clk = ~clk;
  // pull-up: high unless a party pulls low
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  host_i2c_model i_host_i2c_model (
    .i_clk     (clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_low (sda_low)
  );
  charger_host_mode_register_bank #(
    .SAFETY_CYCLES  (48'h0000_0000_00C8),
    .WD_CYCLES_SEL1 (48'h0000_0000_0032),
    .WD_CYCLES_SEL2 (48'h0000_0000_0064),
    .WD_CYCLES_SEL3 (48'h0000_0000_0096)
  ) i_charger_host_mode_register_bank (
    .I_SYS_CLK (clk), .I_RESET (rst), .I_SCL (scl), .I_SDA (sda),
    .O_SDA_OUT (sda_out), .O_SDA_OE (sda_oe), .I_TIMER_KICK (kick),
    .I_WD_PERIOD (period), .I_REG_RESET (reg_rst), .I_DETECT_DONE (det),
    .I_SOURCE_TYPE (src), .I_PIN_SELECT (1'b0), .I_EXT_LIMIT_CODE (ext),
    .I_FLOOR_BASE_MV (base), .I_VBUS_NOLOAD_MV (vbus), .O_TIMER_EXPIRED (expired),
    .O_TIMER_KICK (kick_out), .O_CHARGE_ENABLE (chg), .O_HIGH_IMPEDANCE_STATE (high_impedance_state),
    .O_EXT_LIMIT_PIN_ENABLE (pin_en), .O_INPUT_CURRENT_LIMIT (lim),
    .O_EFFECTIVE_LIMIT (eff), .O_BOOST_HOT_PCT_X100 (hot), .O_BOOST_THERMAL_DISABLE (tdis),
    .O_BOOST_COLD_PCT_X100 (cold), .O_INPUT_VOLTAGE_FLOOR_MV (floor_mv)
  );
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_host_i2c_model.write_reg(DEV, ofs, d, acks);
    check("write acks", 16'h0007, {13'h0, acks});
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    i_host_i2c_model.read_reg(DEV, ofs, rdata, acks);
    check("read acks", 16'h0007, {13'h0, acks});
    check("read data", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    final_report();
  end
  initial begin
    ticks(8);
    rst = 1'b0;
    ticks(1);
    check("expired", 16'h0001, {15'h0, expired});
    check("charge", 16'h0001, {15'h0, chg});
    rd(8'h00, `RST_INPUT_LIMIT_CTRL);
    rd(8'h01, `RST_BOOST_TEMP_VFLOOR);
    check("hot", `HOT_PCT_X100_CODE0, hot);
    check("cold", `COLD_PCT_X100_CODE0, cold);
    check("floor", 16'h11F8, floor_mv);
    ticks(200);
    check("charge", 16'h0000, {15'h0, chg});
    check("expired", 16'h0001, {15'h0, expired});
    wr(8'h00, 8'hC5);
    check("expired", 16'h0000, {15'h0, expired});
    check("charge", 16'h0001, {15'h0, chg});
    check("hiz", 16'h0001, {15'h0, high_impedance_state});
    check("pin enable", 16'h0001, {15'h0, pin_en});
    check("limit", 16'h0005, {10'h0, lim});
    rd(8'h00, 8'hC5);
    ext = 6'h03;
    ticks(2);
    check("effective", 16'h0003, {10'h0, eff});
    wr(8'h00, 8'h05);
    check("effective", 16'h0005, {10'h0, eff});
    check("hiz", 16'h0000, {15'h0, high_impedance_state});
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, {i[1:0], i[0], 5'h06});
      check("thermal off", {15'h0, i == 3}, {15'h0, tdis});
      if (i < 3) check("hot", hot_tab[i], hot);
      check("cold", i[0] ? `COLD_PCT_X100_CODE1 : `COLD_PCT_X100_CODE0, cold);
    end
    for (int i = 0; i < 4; i++) begin
      base = fb[i];
      vbus = fv[i];
      wr(8'h01, {3'b000, fo[i]});
      check("floor", fe[i], floor_mv);
    end
    i_host_i2c_model.write_reg(DEV, 8'h02, 8'h55, acks);
    check("unmapped acks", 16'h0004, {13'h0, acks});
    i_host_i2c_model.write_reg(DEV ^ 7'h01, 8'h00, 8'h55, acks);
    check("foreign acks", 16'h0000, {13'h0, acks});
    rd(8'h00, 8'h05);
    for (int i = 0; i < 4; i++) begin
      src = source_t'(i[1:0]);
      det = 1'b1;
      ticks(1);
      det = 1'b0;
      ticks(1);
      check("detected limit", {10'h0, det_tab[i]}, {10'h0, lim});
    end
    for (int p = 1; p < 4; p++) begin
      period = p[1:0];
      wr(8'h01, 8'hE6);
      wr(8'h00, 8'hD2);
      if (p == 1) begin
        for (int k = 0; k < 8; k++) begin
          ticks(10);
          kick = 1'b1;
          ticks(1);
          kick = 1'b0;
          check("kick bit", 16'h0001, {15'h0, kick_out});
          ticks(2);
          check("kick bit", 16'h0000, {15'h0, kick_out});
        end
      end
      // the write tail already used about 32 cycles of the period
      ticks(wd_len[p - 1] - (p == 1 ? 12 : 40));
      check("expired", 16'h0000, {15'h0, expired});
      ticks(18);
      check("expired", 16'h0001, {15'h0, expired});
      check("hiz", 16'h0000, {15'h0, high_impedance_state});
      rd(8'h00, 8'h12);
      rd(8'h01, 8'h06);
    end
    period = 2'b00;
    wr(8'h00, 8'hC7);
    ticks(400);
    check("expired", 16'h0000, {15'h0, expired});
    wr(8'h01, 8'hFF);
    reg_rst = 1'b1;
    ticks(1);
    reg_rst = 1'b0;
    rd(8'h00, `RST_INPUT_LIMIT_CTRL);
    rd(8'h01, `RST_BOOST_TEMP_VFLOOR);
    final_report();
  end
endmodule // charger_host_mode_register_bank_bench
